// *** pkg/shreg_pkg.sv ***
// Constants and types of the sign-extend shift register
package shreg_pkg;

	// ==================================================
	// Stage layout
	localparam int STAGES    = 8;
	localparam int FIRST_IDX = 0;
	localparam int LAST_IDX  = STAGES - 1;
	localparam logic [STAGES-1:0] STAGE_ZERO = 8'h00;

	// ==================================================
	// Capture buffer
	localparam int FIFO_DEPTH = 2;
	localparam logic [1:0] CNT_EMPTY = 2'h0;
	localparam logic [1:0] CNT_ONE   = 2'h1;
	localparam logic [1:0] CNT_FULL  = 2'h2;
	localparam logic       PTR_ZERO  = 1'h0;
	localparam logic       PTR_STEP  = 1'h1;

	// ==================================================
	// Clock
	localparam int CLK_PERIOD_NS = 20;

	// ==================================================
	// Decoded operation
	typedef enum logic [3:0] {
		OP_HOLD  = 4'h1,
		OP_LOAD  = 4'h2,
		OP_SHIFT = 4'h4,
		OP_SIGN  = 4'h8
	} op_t;

	// ==================================================
	// Whole module state
	typedef struct packed {
		logic [STAGES-1:0]                 stage;
		logic [FIFO_DEPTH-1:0][STAGES-1:0] mem;
		logic                              wr_ptr;
		logic                              rd_ptr;
		logic [1:0]                        count;
	} state_t;

endpackage

// *** rtl/shift_register_sign_extend.sv ***
// Eight-stage right shift register with sign extend and shared terminals
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - A shift fills the first stage from one of two serial inputs.
// - Dedicated cascade output carries the last stage for chaining.
// - Enable and serial/parallel select both low load the terminals.
// - In load mode the terminals are inputs and are not driven.
// - Loads, shifts and sign extends act on the rising clock edge only.
// - Sign extend shifts right while the first stage keeps its value.
// - Clear low zeroes all stages at once, without a clock edge.
// - Output enable touches only terminal drive, never the stages.
// - Enable high holds every stage across clock edges.
// - Normal shift moves each stage one place toward the last.
// - Output enable high puts the terminals in high impedance.
// - Clear during load mode clears stages and keeps terminals undriven.
module shift_register_sign_extend
	import shreg_pkg::*;
(
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst_n,
	input  wire logic              i_async_clear_n,
	input  wire logic              i_register_enable_n,
	input  wire logic              i_serial_parallel_n,
	input  wire logic              i_sign_extend_n,
	input  wire logic              i_serial_input_select,
	input  wire logic              i_serial_in_first,
	input  wire logic              i_serial_in_second,
	input  wire logic              i_output_enable_n,
	input  wire logic [STAGES-1:0] i_io_terminal,
	output logic      [STAGES-1:0] o_io_terminal,
	output logic                   o_io_terminal_oe,
	output logic                   o_cascade_serial_out,
	input  wire logic              i_capture_valid,
	output logic                   o_capture_ready,
	output logic                   o_word_valid,
	output logic      [STAGES-1:0] o_word_data,
	input  wire logic              i_word_ready
);

	// ==================================================
	// Declarations
	state_t            state_r;
	state_t            state_nxt;
	op_t               op;
	logic              fill_bit;
	logic              push;
	logic              pop;
	logic              step_ok;

	// ==================================================
	// Operation decode
	always_comb begin
		if (i_register_enable_n) begin
			op = OP_HOLD;
		end else if (!i_serial_parallel_n) begin
			op = OP_LOAD;
		end else if (i_sign_extend_n) begin
			op = OP_SHIFT;
		end else begin
			op = OP_SIGN;
		end
	end

	assign fill_bit = i_serial_input_select ? i_serial_in_second
	                                        : i_serial_in_first;

	// ==================================================
	// Capture buffer handshake
	assign o_capture_ready = (state_r.count != CNT_FULL);
	assign o_word_valid    = (state_r.count != CNT_EMPTY);
	assign push            = i_capture_valid && o_capture_ready;
	assign pop             = o_word_valid && i_word_ready;
	assign o_word_data     = state_r.mem[state_r.rd_ptr];

	// ==================================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		case (op)
			OP_HOLD: begin
				state_nxt.stage = state_r.stage;
			end
			OP_LOAD: begin
				state_nxt.stage = i_io_terminal;
			end
			OP_SHIFT: begin
				state_nxt.stage = {state_r.stage[LAST_IDX-1:FIRST_IDX],
				                   fill_bit};
			end
			OP_SIGN: begin
				state_nxt.stage = {state_r.stage[LAST_IDX-1:FIRST_IDX],
				                   state_r.stage[FIRST_IDX]};
			end
			default: begin
				state_nxt.stage = state_r.stage;
			end
		endcase
		if (push) begin
			state_nxt.mem[state_r.wr_ptr] = state_r.stage;
			state_nxt.wr_ptr = state_r.wr_ptr + PTR_STEP;
		end
		if (pop) begin
			state_nxt.rd_ptr = state_r.rd_ptr + PTR_STEP;
		end
		if (push && !pop) begin
			state_nxt.count = state_r.count + CNT_ONE;
		end else if (pop && !push) begin
			state_nxt.count = state_r.count - CNT_ONE;
		end
		if (!i_rst_n) begin
			state_nxt = '0;
		end
	end

	// ==================================================
	// State register
	// rising clock edge only; clear low zeroes it at once
	always_ff @(posedge i_clk_sys or negedge i_async_clear_n) begin
		if (!i_async_clear_n) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==================================================
	// Pins
	assign o_io_terminal = state_r.stage;
	// clear does not change the release
	assign o_io_terminal_oe = !i_output_enable_n && (op != OP_LOAD);
	assign o_cascade_serial_out = state_r.stage[LAST_IDX];

	// ==================================================
	// Checks
	assign step_ok = i_rst_n && i_async_clear_n;

	property p_fill_select;
		@(posedge i_clk_sys) disable iff (!i_rst_n || !i_async_clear_n)
		(step_ok && op == OP_SHIFT) |=>
			state_r.stage[FIRST_IDX] ==
			($past(i_serial_input_select) ? $past(i_serial_in_second)
			                              : $past(i_serial_in_first));
	endproperty
	a_fill_select: assert property (p_fill_select)
		else $error("first stage not filled from selected input");

	property p_cascade;
		@(posedge i_clk_sys) disable iff (!i_rst_n || !i_async_clear_n)
		(step_ok && (op == OP_SHIFT || op == OP_SIGN)) |=>
			o_cascade_serial_out == $past(state_r.stage[LAST_IDX-1]);
	endproperty
	a_cascade: assert property (p_cascade)
		else $error("cascade output does not follow last stage");

	property p_load;
		@(posedge i_clk_sys) disable iff (!i_rst_n || !i_async_clear_n)
		(step_ok && op == OP_LOAD) |=> o_io_terminal == $past(i_io_terminal);
	endproperty
	a_load: assert property (p_load)
		else $error("parallel load missed terminal levels");

	property p_load_release;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(!i_register_enable_n && !i_serial_parallel_n) |->
			!o_io_terminal_oe;
	endproperty
	a_load_release: assert property (p_load_release)
		else $error("terminals driven during load mode");

	property p_no_fall_change;
		@(posedge i_clk_sys) disable iff (!i_rst_n || !i_async_clear_n)
		step_ok |=> state_r.stage == $past(state_nxt.stage);
	endproperty
	a_no_fall_change: assert property (p_no_fall_change)
		else $error("stages changed on falling clock edge");

	property p_sign;
		@(posedge i_clk_sys) disable iff (!i_rst_n || !i_async_clear_n)
		(step_ok && op == OP_SIGN) |=>
			state_r.stage == {$past(state_r.stage[LAST_IDX-1:FIRST_IDX]),
			                  $past(state_r.stage[FIRST_IDX])};
	endproperty
	a_sign: assert property (p_sign)
		else $error("sign extend shift wrong");

	property p_clear;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		!i_async_clear_n |-> (state_r.stage == STAGE_ZERO);
	endproperty
	a_clear: assert property (p_clear)
		else $error("stages not zero while clear is low");

	property p_oe_no_effect;
		@(posedge i_clk_sys) disable iff (!i_rst_n || !i_async_clear_n)
		(step_ok && i_output_enable_n && op == OP_SHIFT) |=>
			state_r.stage[LAST_IDX:FIRST_IDX+1] ==
			$past(state_r.stage[LAST_IDX-1:FIRST_IDX]);
	endproperty
	a_oe_no_effect: assert property (p_oe_no_effect)
		else $error("shift stopped while outputs disabled");

	property p_hold;
		@(posedge i_clk_sys) disable iff (!i_rst_n || !i_async_clear_n)
		(step_ok && op == OP_HOLD) |=> $stable(state_r.stage);
	endproperty
	a_hold: assert property (p_hold)
		else $error("stages changed during hold");

	property p_shift;
		@(posedge i_clk_sys) disable iff (!i_rst_n || !i_async_clear_n)
		(step_ok && op == OP_SHIFT) [*2] |=>
			state_r.stage[LAST_IDX:FIRST_IDX+1] ==
			$past(state_r.stage[LAST_IDX-1:FIRST_IDX]);
	endproperty
	a_shift: assert property (p_shift)
		else $error("stages did not move toward last stage");

	property p_oe_off;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_output_enable_n |-> !o_io_terminal_oe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("terminals driven with output enable high");

	property p_fifo_bound;
		@(posedge i_clk_sys) disable iff (!i_rst_n || !i_async_clear_n)
		(step_ok && state_r.count == CNT_FULL && i_capture_valid &&
		 !i_word_ready) |=>
			state_r.count == CNT_FULL && $stable(state_r.mem);
	endproperty
	a_fifo_bound: assert property (p_fifo_bound)
		else $error("capture accepted while buffer full");

	property p_sync_reset;
		@(posedge i_clk_sys) disable iff (!i_async_clear_n)
		!i_rst_n |=> state_r.stage == STAGE_ZERO && !o_word_valid;
	endproperty
	a_sync_reset: assert property (p_sync_reset)
		else $error("synchronous reset left state behind");

	property p_push_store;
		@(posedge i_clk_sys) disable iff (!i_rst_n || !i_async_clear_n)
		(step_ok && push && state_r.count == CNT_EMPTY) |=>
			o_word_valid && o_word_data == $past(state_r.stage);
	endproperty
	a_push_store: assert property (p_push_store)
		else $error("captured word not presented");

	property p_pop_count;
		@(posedge i_clk_sys) disable iff (!i_rst_n || !i_async_clear_n)
		(step_ok && pop && !push) |=>
			state_r.count == $past(state_r.count) - CNT_ONE;
	endproperty
	a_pop_count: assert property (p_pop_count)
		else $error("buffer count did not drop after pop");

	property p_hold_drive;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(!i_output_enable_n && i_register_enable_n) |-> o_io_terminal_oe;
	endproperty
	a_hold_drive: assert property (p_hold_drive)
		else $error("terminals released in hold mode");

	property p_clear_empties;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		!i_async_clear_n |-> !o_word_valid && o_capture_ready;
	endproperty
	a_clear_empties: assert property (p_clear_empties)
		else $error("buffer kept words while clear is low");

	c_load_then_shift: cover property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(op == OP_LOAD) ##1 (op == OP_SHIFT) [*3]);
	c_sign_run: cover property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(op == OP_SIGN) [*4]);
	c_clear_in_load: cover property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		!i_async_clear_n && op == OP_LOAD);
	c_fifo_full: cover property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		state_r.count == CNT_FULL ##1 pop);
	c_full_refused: cover property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		state_r.count == CNT_FULL && i_capture_valid);

endmodule

`default_nettype wire

// *** verification/io_bus_model.sv ***
// Bus side model of the eight shared terminals
`timescale 1ns/1ns
`default_nettype none
module io_bus_model
	import shreg_pkg::*;
(
	input  wire logic              i_clk_sys,
	input  wire logic              i_drv_en,
	input  wire logic [STAGES-1:0] i_drv_data,
	input  wire logic              i_dut_oe,
	input  wire logic [STAGES-1:0] i_dut_data,
	output logic      [STAGES-1:0] o_bus
);
	logic [STAGES-1:0] last_r;

	// ====
	// Wire level
	// drive only when free
	always_comb begin
		if (i_dut_oe)
			o_bus = i_dut_data;
		else if (i_drv_en)
			o_bus = i_drv_data;
		else
			o_bus = ~last_r;
	end

	always_ff @(posedge i_clk_sys) begin
		last_r <= o_bus;
	end
endmodule
`default_nettype wire

// *** verification/test_shift_register_sign_extend.sv ***
// Testbench of the sign-extend shift register
`timescale 1ns/1ns
`default_nettype none
module test_shift_register_sign_extend
	import shreg_pkg::*;
;
	localparam logic [3:0] M_LOAD = 4'h0;
	localparam logic [3:0] M_SH0  = 4'h6;
	localparam logic [3:0] M_SH1  = 4'h7;
	localparam logic [3:0] M_SIGN = 4'h4;
	localparam logic [3:0] M_HOLD = 4'h8;
	logic              clk, rst_n, clr_n, en_n, sp_n, se_n, sel;
	logic              sin0, sin1, oe_n, cap_v, wrdy, drv_en;
	logic              oe, casc, cap_rdy, wvalid;
	logic [STAGES-1:0] drv_d, bus, q, wdata;
	int                failures = 0;
	int                n_checks = 0;
	int                cycles   = 0;

	shift_register_sign_extend dut (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_async_clear_n(clr_n), .i_register_enable_n(en_n),
		.i_serial_parallel_n(sp_n), .i_sign_extend_n(se_n),
		.i_serial_input_select(sel), .i_serial_in_first(sin0),
		.i_serial_in_second(sin1), .i_output_enable_n(oe_n),
		.i_io_terminal(bus), .o_io_terminal(q), .o_io_terminal_oe(oe),
		.o_cascade_serial_out(casc), .i_capture_valid(cap_v),
		.o_capture_ready(cap_rdy), .o_word_valid(wvalid),
		.o_word_data(wdata), .i_word_ready(wrdy));

	io_bus_model partner (.i_clk_sys(clk), .i_drv_en(drv_en),
		.i_drv_data(drv_d), .i_dut_oe(oe), .i_dut_data(q), .o_bus(bus));

	// ====
	// Clock, timeout and report
	initial begin
		clk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles > 600) begin
			failures++;
			$display("BAD %0t timeout", $time);
			end_sim();
		end
	end

	task automatic end_sim();
		if (failures == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk8(input logic [STAGES-1:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t bit %b expected %b", $time, got, exp);
		end
	endtask

	// Mode for the next edge; bus drives only in load mode
	task automatic set(input logic [3:0] m, input logic [STAGES-1:0] d);
		@(posedge clk);
		{en_n, sp_n, se_n, sel} <= m;
		drv_en <= (m[3:2] == 2'h0);
		drv_d <= d;
	endtask

	// ====
	// Scenarios
	task automatic t_load();
		set(M_LOAD, 8'hA5);
		#1 chk1(oe, 1'b0);
		set(M_HOLD, 8'h00);
		#1 chk8(q, 8'hA5);
		chk1(casc, 1'b1);
		chk1(oe, 1'b1);
	endtask

	task automatic t_shift();
		set(M_SH0, 8'h00);
		sin0 <= 1'b1;
		sin1 <= 1'b0;
		set(M_SH1, 8'h00);
		#1 chk8(q, 8'h4B);
		chk1(casc, 1'b0);
		set(M_HOLD, 8'h00);
		#1 chk8(q, 8'h96);
	endtask

	task automatic t_sign();
		set(M_LOAD, 8'h81);
		set(M_SIGN, 8'h00);
		set(M_SIGN, 8'h00);
		oe_n <= 1'b1;
		set(M_HOLD, 8'h00);
		#1 chk8(q, 8'h07);
		chk1(oe, 1'b0);
		set(M_HOLD, 8'h00);
		#1 chk8(q, 8'h07);
		chk1(casc, 1'b0);
	endtask

	task automatic t_edge_clear();
		set(M_LOAD, 8'h3C);
		oe_n <= 1'b0;
		@(negedge clk) chk8(q, 8'h07);
		set(M_LOAD, 8'hFF);
		clr_n <= 1'b0;
		#1 chk8(q, 8'h00);
		chk1(oe, 1'b0);
		set(M_HOLD, 8'h00);
		clr_n <= 1'b1;
		#1 chk8(q, 8'h00);
	endtask

	task automatic t_buffer();
		set(M_LOAD, 8'h5A);
		set(M_LOAD, 8'h11);
		cap_v <= 1'b1;
		set(M_LOAD, 8'h22);
		set(M_HOLD, 8'h00);
		set(M_HOLD, 8'h00);
		cap_v <= 1'b0;
		wrdy <= 1'b1;
		#1 chk1(cap_rdy, 1'b0);
		chk8(wdata, 8'h5A);
		set(M_HOLD, 8'h00);
		#1 chk8(wdata, 8'h11);
		chk1(wvalid, 1'b1);
		set(M_HOLD, 8'h00);
		#1 chk1(wvalid, 1'b0);
		chk1(cap_rdy, 1'b1);
	endtask

	// ====
	// Main sequence
	initial begin
		{rst_n, clr_n, sin0, sin1, oe_n, cap_v, wrdy} = 7'h20;
		{en_n, sp_n, se_n, sel, drv_en} = 5'h10;
		drv_d = 8'h00;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk8(q, 8'h00);
		t_load();
		t_shift();
		t_sign();
		t_edge_clear();
		t_buffer();
		end_sim();
	end
endmodule
`default_nettype wire
